// File: rsd_ctrl.sv
// reference clock, clock-out divider and synthesizer divider control
`timescale 1ns/1ps
module rsd_ctrl
	import rsd_pkg::*;
#(
	parameter int REG_READY_CYCLES = REG_READY_CYC
) (
	input wire logic mclk,
	input wire logic rst,
	input wire logic chip_enable,
	input wire logic cfg_wr0,
	input wire logic cfg_wr1,
	input wire logic [7:0] int_n_in,
	input wire logic [14:0] frac_n_in,
	input wire logic [2:0] status_mux_sel_in,
	input wire logic crystal_osc_enable_bit,
	input wire logic [1:0] crystal_bias_field,
	input wire logic [3:0] clk_div_field,
	input wire logic [2:0] ref_div_field,
	input wire logic output_halving_select,
	input wire logic pfd_sample,
	input wire logic [7:0] phase_err_ns,
	output logic osc_enable,
	output logic [1:0] osc_bias,
	output logic divided_ref_output,
	output logic pfd_ref_tick,
	output logic [8:0] fb_div_n,
	output logic fb_halve,
	output logic regulator_ready,
	output logic lock_detect,
	output logic status_mux_pin
);
	typedef struct packed {
		logic ce_meta;
		logic ce_sync;
		logic [RDY_W-1:0] rdy_cnt;
		logic rdy;
		logic osc_en;
		logic [BIAS_W-1:0] bias;
		logic [CKDIV_W-1:0] ckdiv;
		logic [RDIV_W-1:0] rdiv;
		logic [INT_W-1:0] int_n;
		logic [FRAC_W-1:0] frac;
		logic halve;
		logic [MUX_W-1:0] mux;
		logic clk_out;
		logic pfd_ref;
		logic [FRAC_W-1:0] acc;
		logic [8:0] n_div;
		logic [2:0] lk_cnt;
		logic lock;
		logic mux_out;
	} rsd_st_t;

	rsd_st_t st_reg;
	rsd_st_t st_next;

	logic ck_clr;
	logic ck_tick;
	logic r_tick;
	logic [CKDIV_W-1:0] ck_limit;
	logic [RDIV_W-1:0] r_limit;
	logic [FRAC_W:0] acc_sum;

	// ==========================================================
	// dividers
	// nonzero k in the field toggles every k cycles: period 2k, always even; zero holds the output low
	assign ck_clr = !st_reg.ce_sync || (st_reg.ckdiv == '0);
	assign ck_limit = st_reg.ckdiv - 1'b1;
	// a zero reference ratio is treated as one rather than stalling the loop
	assign r_limit = (st_reg.rdiv == '0) ? '0 : st_reg.rdiv - 1'b1;

	rsd_div_cnt #(
		.W(CKDIV_W)
	) u_ck_div (
		.mclk(mclk),
		.rst(rst),
		.clr(ck_clr),
		.limit(ck_limit),
		.tick(ck_tick)
	);

	rsd_div_cnt #(
		.W(RDIV_W)
	) u_ref_div (
		.mclk(mclk),
		.rst(rst),
		.clr(!st_reg.ce_sync),
		.limit(r_limit),
		.tick(r_tick)
	);

	assign acc_sum = {1'b0, st_reg.acc} + {1'b0, st_reg.frac};

	// ==========================================================
	// next state
	always_comb begin
		st_next = st_reg;
		st_next.ce_meta = chip_enable;
		st_next.ce_sync = st_reg.ce_meta;

		if (!st_reg.ce_sync) begin
			// chip enable low: regulator off, all settings lost
			st_next.rdy_cnt = '0;
			st_next.rdy = 1'b0;
			st_next.osc_en = OSC_EN_RST;
			st_next.bias = BIAS_RST;
			st_next.ckdiv = CKDIV_RST;
			st_next.rdiv = RDIV_RST;
			st_next.int_n = INT_RST;
			st_next.frac = FRAC_RST;
			st_next.halve = HALVE_RST;
			st_next.mux = MUX_REG_READY;
			st_next.clk_out = 1'b0;
			st_next.pfd_ref = 1'b0;
			st_next.acc = '0;
			st_next.n_div = {1'b0, INT_RST};
			st_next.lk_cnt = '0;
			st_next.lock = 1'b0;
		end else begin
			// regulator settle timer
			if (st_reg.rdy_cnt >= RDY_W'(REG_READY_CYCLES - 1)) begin
				st_next.rdy = 1'b1;
			end else begin
				st_next.rdy_cnt = st_reg.rdy_cnt + 1'b1;
			end

			// the serial port is unpowered until ready, so writes are dropped
			if (st_reg.rdy && cfg_wr0) begin
				st_next.int_n = int_n_in;
				st_next.frac = frac_n_in;
				st_next.mux = status_mux_sel_in;
			end
			if (st_reg.rdy && cfg_wr1) begin
				st_next.osc_en = crystal_osc_enable_bit;
				st_next.bias = crystal_bias_field;
				st_next.ckdiv = clk_div_field;
				st_next.rdiv = ref_div_field;
				st_next.halve = output_halving_select;
			end

			// clock-out toggles on every wrap of the half-period counter
			if (ck_clr) begin
				st_next.clk_out = 1'b0;
			end else if (ck_tick) begin
				st_next.clk_out = !st_reg.clk_out;
			end

			// reference pulse and fractional accumulator step per pfd cycle
			st_next.pfd_ref = r_tick;
			if (r_tick) begin
				st_next.acc = acc_sum[FRAC_W-1:0];
				st_next.n_div = {1'b0, st_reg.int_n} + {8'h00, acc_sum[FRAC_W]};
			end

			// lock detect with hysteresis between the two error limits
			if (pfd_sample) begin
				if (phase_err_ns >= LOCK_CLR_NS) begin
					st_next.lock = 1'b0;
					st_next.lk_cnt = '0;
				end else if (phase_err_ns < LOCK_SET_NS) begin
					if (st_reg.lk_cnt >= LOCK_CYCLES - 1'b1) begin
						st_next.lock = 1'b1;
					end else begin
						st_next.lk_cnt = st_reg.lk_cnt + 1'b1;
					end
				end else begin
					st_next.lk_cnt = '0;
				end
			end
		end

		// status pin selection
		unique case (st_next.mux)
			MUX_REG_READY: st_next.mux_out = st_next.rdy;
			MUX_LOCK: st_next.mux_out = st_next.lock;
			MUX_PFD_REF: st_next.mux_out = st_next.pfd_ref;
			MUX_CLK_OUT: st_next.mux_out = st_next.clk_out;
			default: st_next.mux_out = 1'b0;
		endcase
	end

	// ==========================================================
	// registers
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			st_reg.ce_meta <= 1'b0;
			st_reg.ce_sync <= 1'b0;
			st_reg.rdy_cnt <= '0;
			st_reg.rdy <= 1'b0;
			st_reg.osc_en <= OSC_EN_RST;
			st_reg.bias <= BIAS_RST;
			st_reg.ckdiv <= CKDIV_RST;
			st_reg.rdiv <= RDIV_RST;
			st_reg.int_n <= INT_RST;
			st_reg.frac <= FRAC_RST;
			st_reg.halve <= HALVE_RST;
			st_reg.mux <= MUX_REG_READY;
			st_reg.clk_out <= 1'b0;
			st_reg.pfd_ref <= 1'b0;
			st_reg.acc <= '0;
			st_reg.n_div <= {1'b0, INT_RST};
			st_reg.lk_cnt <= '0;
			st_reg.lock <= 1'b0;
			st_reg.mux_out <= 1'b0;
		end else begin
			st_reg <= st_next;
		end
	end

	// ==========================================================
	// outputs
	// the real oscillator is analog; this enable gates it with chip enable
	assign osc_enable = st_reg.osc_en && st_reg.ce_sync;
	assign osc_bias = st_reg.bias;
	// sampled on the rising edge, so edges sit half a period after
	// the falling reference edge when the pad inverts it
	assign divided_ref_output = st_reg.clk_out;
	assign pfd_ref_tick = st_reg.pfd_ref;
	assign fb_div_n = st_reg.n_div;
	assign fb_halve = st_reg.halve;
	assign regulator_ready = st_reg.rdy;
	assign lock_detect = st_reg.lock;
	assign status_mux_pin = st_reg.mux_out;

	// ==========================================================
	// checks
	a_ce_clear: assert property (@(posedge mclk) disable iff (rst)
		!st_reg.ce_sync |=> st_reg.ckdiv == CKDIV_RST && st_reg.rdiv == RDIV_RST
			&& !regulator_ready && st_reg.mux == MUX_REG_READY)
		else $error("settings not cleared while chip enable low");

	a_osc_off: assert property (@(posedge mclk) disable iff (rst)
		!st_reg.ce_sync |-> !osc_enable)
		else $error("oscillator enabled with chip enable low");

	a_ck_disabled: assert property (@(posedge mclk) disable iff (rst)
		(st_reg.ckdiv == 4'h0) [*2] |-> !divided_ref_output)
		else $error("clock output runs with ratio zero");

	a_ck_half_period: assert property (@(posedge mclk) disable iff (rst)
		(st_reg.ce_sync && st_reg.ckdiv == 4'h2 && $changed(divided_ref_output)
			&& $stable(st_reg.ckdiv)) [*1] ##1 (st_reg.ckdiv == 4'h2 && st_reg.ce_sync)
		|-> $stable(divided_ref_output))
		else $error("clock output half period shorter than k");

	a_ready_late: assert property (@(posedge mclk) disable iff (rst)
		$rose(regulator_ready) |-> st_reg.rdy_cnt >= RDY_W'(REG_READY_CYCLES - 1))
		else $error("regulator ready before settle time");

	a_write_drop: assert property (@(posedge mclk) disable iff (rst)
		st_reg.ce_sync && !regulator_ready && st_reg.ce_sync ##1 st_reg.ce_sync
		|-> $stable(st_reg.int_n) && $stable(st_reg.ckdiv))
		else $error("setting changed before regulator ready");

	a_lock_drop: assert property (@(posedge mclk) disable iff (rst)
		pfd_sample && phase_err_ns >= LOCK_CLR_NS |=> !lock_detect)
		else $error("lock held after large phase error");

	a_lock_need5: assert property (@(posedge mclk) disable iff (rst)
		$rose(lock_detect) |-> $past(st_reg.lk_cnt) == LOCK_CYCLES - 3'h1)
		else $error("lock set before five good cycles");

	// pin is registered from the next-state selection, so it matches the stored source
	a_mux_ready: assert property (@(posedge mclk) disable iff (rst)
		st_reg.mux == MUX_REG_READY |-> status_mux_pin == regulator_ready)
		else $error("status pin does not follow regulator ready");

	a_mux_ref: assert property (@(posedge mclk) disable iff (rst)
		st_reg.mux == MUX_PFD_REF |-> status_mux_pin == pfd_ref_tick)
		else $error("status pin does not follow reference tick");

	a_lock_hold: assert property (@(posedge mclk) disable iff (rst)
		pfd_sample && phase_err_ns >= LOCK_SET_NS && phase_err_ns < LOCK_CLR_NS
			&& st_reg.ce_sync |=> lock_detect == $past(lock_detect))
		else $error("lock changed inside the hysteresis band");

	// division is updated with the tick from the integer of the cycle before
	a_fb_range: assert property (@(posedge mclk) disable iff (rst)
		pfd_ref_tick |-> fb_div_n <= 9'h100
			&& (fb_div_n - {1'b0, $past(st_reg.int_n)}) <= 9'h001)
		else $error("feedback division out of range");

	c_ready: cover property (@(posedge mclk) disable iff (rst) $rose(regulator_ready));
	c_lock: cover property (@(posedge mclk) disable iff (rst) $rose(lock_detect));
	c_carry: cover property (@(posedge mclk) disable iff (rst)
		fb_div_n == {1'b0, st_reg.int_n} + 9'h001);
	c_ck_off: cover property (@(posedge mclk) disable iff (rst)
		st_reg.ce_sync && st_reg.ckdiv == 4'h0);
	c_ref_mux: cover property (@(posedge mclk) disable iff (rst)
		st_reg.mux == MUX_PFD_REF);
endmodule

// File: rsd_pkg.sv
// constants for the reference, clock-out and synthesizer divider control
package rsd_pkg;
	// ==========================================================
	// timing
	localparam int CLK_PERIOD_NS = 10;
	localparam int REG_READY_US = 50;
	localparam int REG_READY_CYC = (REG_READY_US * 1000) / CLK_PERIOD_NS;
	localparam int RDY_W = 16;
	// ==========================================================
	// field widths
	localparam int BIAS_W = 2;
	localparam int CKDIV_W = 4;
	localparam int RDIV_W = 3;
	localparam int INT_W = 8;
	localparam int FRAC_W = 15;
	localparam int MUX_W = 3;
	// ==========================================================
	// values after power-up or chip-enable low
	localparam logic OSC_EN_RST = 1'h1;
	localparam logic [1:0] BIAS_RST = 2'h0;
	localparam logic [3:0] CKDIV_RST = 4'h4;
	localparam logic [2:0] RDIV_RST = 3'h1;
	localparam logic [7:0] INT_RST = 8'h17;
	localparam logic [14:0] FRAC_RST = 15'h0000;
	localparam logic HALVE_RST = 1'h0;
	// ==========================================================
	// status output selections
	localparam logic [2:0] MUX_REG_READY = 3'h0;
	localparam logic [2:0] MUX_LOCK = 3'h1;
	localparam logic [2:0] MUX_PFD_REF = 3'h2;
	localparam logic [2:0] MUX_CLK_OUT = 3'h3;
	// ==========================================================
	// lock detect, phase error in ns
	localparam logic [7:0] LOCK_SET_NS = 8'h0F;
	localparam logic [7:0] LOCK_CLR_NS = 8'h19;
	localparam logic [2:0] LOCK_CYCLES = 3'h5;
endpackage

// File: rsd_div_cnt.sv
// programmable wrap counter used by the clock-out and reference dividers
`timescale 1ns/1ps
module rsd_div_cnt #(
	parameter int W = 4
) (
	input wire logic mclk,
	input wire logic rst,
	input wire logic clr,
	input wire logic [W-1:0] limit,
	output logic tick
);
	typedef struct packed {
		logic [W-1:0] cnt;
	} rsd_cnt_st_t;

	rsd_cnt_st_t st_reg;
	rsd_cnt_st_t st_next;

	// ==========================================================
	// count
	// >= so a smaller limit written mid-count wraps at once
	always_comb begin
		st_next = st_reg;
		tick = 1'b0;
		if (clr) begin
			st_next.cnt = '0;
		end else if (st_reg.cnt >= limit) begin
			st_next.cnt = '0;
			tick = 1'b1;
		end else begin
			st_next.cnt = st_reg.cnt + 1'b1;
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	a_wrap_tick: assert property (@(posedge mclk) disable iff (rst)
		tick |=> st_reg.cnt == '0)
		else $error("divider did not wrap after tick");
endmodule

// File: rsd_host.sv
// host controller model that programs the divider control block
`timescale 1ns/1ps
module rsd_host (
	input wire logic mclk,
	input wire logic regulator_ready,
	output logic cfg_wr0,
	output logic cfg_wr1,
	output logic [7:0] int_n_in,
	output logic [14:0] frac_n_in,
	output logic [2:0] status_mux_sel_in,
	output logic crystal_osc_enable_bit,
	output logic [1:0] crystal_bias_field,
	output logic [3:0] clk_div_field,
	output logic [2:0] ref_div_field,
	output logic output_halving_select
);
	// ==========================================================
	// idle values
	initial begin
		{cfg_wr0, cfg_wr1, int_n_in, frac_n_in, status_mux_sel_in} = '0;
		{crystal_osc_enable_bit, crystal_bias_field, clk_div_field} = '0;
		{ref_div_field, output_halving_select} = '0;
	end
	// ==========================================================
	// writes wait for the interface supply; after each write all wr0 data inverts, but only the clock and reference divider fields of wr1
	task automatic wait_ready();
		int n;
		n = 0;
		while (regulator_ready !== 1'h1 && n < 300) begin
			@(posedge mclk);
			n++;
		end
	endtask
	task automatic wr0(input logic [7:0] i, input logic [14:0] f, input logic [2:0] s);
		@(posedge mclk);
		wait_ready();
		cfg_wr0 <= 1'h1;
		int_n_in <= (i < 8'h17) ? 8'h17 : i;
		frac_n_in <= f;
		status_mux_sel_in <= s;
		@(posedge mclk);
		cfg_wr0 <= 1'h0;
		{int_n_in, frac_n_in, status_mux_sel_in} <= ~{int_n_in, frac_n_in, status_mux_sel_in};
	endtask
	task automatic wr1(input logic e, input logic [1:0] b, input logic [3:0] k,
		input logic [2:0] r, input logic h);
		@(posedge mclk);
		wait_ready();
		cfg_wr1 <= 1'h1;
		{crystal_osc_enable_bit, crystal_bias_field, clk_div_field} <= {e, b, k};
		{ref_div_field, output_halving_select} <= {r, h};
		@(posedge mclk);
		cfg_wr1 <= 1'h0;
		{clk_div_field, ref_div_field} <= ~{clk_div_field, ref_div_field};
	endtask
endmodule

// File: reference_synth_divider_ctrl_test.sv
// self-checking testbench for the divider control block
`timescale 1ns/1ps
module reference_synth_divider_ctrl_test;
	import rsd_pkg::*;
	logic mclk = 1'h0;
	logic rst = 1'h1;
	logic chip_enable = 1'h1;
	logic pfd_sample = 1'h0;
	logic [7:0] phase_err_ns = 8'h00;
	logic cfg_wr0, cfg_wr1, crystal_osc_enable_bit, output_halving_select;
	logic [7:0] int_n_in;
	logic [14:0] frac_n_in;
	logic [2:0] status_mux_sel_in, ref_div_field;
	logic [1:0] crystal_bias_field, osc_bias;
	logic [3:0] clk_div_field;
	logic osc_enable, divided_ref_output, pfd_ref_tick, fb_halve;
	logic regulator_ready, lock_detect, status_mux_pin;
	logic [8:0] fb_div_n;
	int miscompares = 0;
	int samples_checked = 0;
	always #5 mclk = ~mclk;
	// ==========================================================
	// instances; short ready count keeps power-up quick
	rsd_ctrl #(.REG_READY_CYCLES(20)) dut (.mclk, .rst, .chip_enable, .cfg_wr0, .cfg_wr1,
		.int_n_in, .frac_n_in, .status_mux_sel_in, .crystal_osc_enable_bit,
		.crystal_bias_field, .clk_div_field, .ref_div_field, .output_halving_select,
		.pfd_sample, .phase_err_ns, .osc_enable, .osc_bias, .divided_ref_output,
		.pfd_ref_tick, .fb_div_n, .fb_halve, .regulator_ready, .lock_detect, .status_mux_pin);
	rsd_host host (.mclk, .regulator_ready, .cfg_wr0, .cfg_wr1, .int_n_in, .frac_n_in,
		.status_mux_sel_in, .crystal_osc_enable_bit, .crystal_bias_field, .clk_div_field,
		.ref_div_field, .output_halving_select);
	// ==========================================================
	// helpers
	task automatic check(input logic [8:0] seen, input logic [8:0] exp, input string what);
		samples_checked++;
		if (seen !== exp) begin
			miscompares++;
			$display("wrong value at %0t: %s seen %0h expected %0h", $time, what, seen, exp);
		end
	endtask
	// high and low run lengths of one clock-out period, bounded
	task automatic clk_len(output int hi, output int lo);
		int t;
		{hi, lo, t} = '0;
		while (divided_ref_output !== 1'h0 && t < 100) begin @(negedge mclk); t++; end
		while (divided_ref_output !== 1'h1 && t < 200) begin @(negedge mclk); t++; end
		while (divided_ref_output === 1'h1 && t < 300) begin @(negedge mclk); t++; hi++; end
		while (divided_ref_output === 1'h0 && t < 400) begin @(negedge mclk); t++; lo++; end
	endtask
	task automatic tick_gap(output int n);
		int t;
		{n, t} = '0;
		while (pfd_ref_tick !== 1'h1 && t < 50) begin @(negedge mclk); t++; end
		do begin @(negedge mclk); n++; end while (pfd_ref_tick !== 1'h1 && n < 50);
	endtask
	task automatic pfd(input logic [7:0] e);
		@(posedge mclk);
		pfd_sample <= 1'h1;
		phase_err_ns <= e;
		@(posedge mclk);
		pfd_sample <= 1'h0;
		phase_err_ns <= ~e;
	endtask
	// ==========================================================
	// scenarios
	task automatic t_defaults();
		int hi, lo;
		host.wait_ready();
		@(negedge mclk);
		check(status_mux_pin, 1'h1, "ready on status pin");
		check(osc_enable, 1'h1, "osc on");
		check(fb_div_n, 9'h017, "int default");
		clk_len(hi, lo);
		check(hi, 9'h004, "default high");
		check(lo, 9'h004, "default low");
		tick_gap(hi);
		check(hi, 9'h001, "ref default");
		$display("test defaults done");
	endtask
	task automatic t_divided_ref_output();
		int hi, lo;
		logic [3:0] ks[4] = '{4'h1, 4'h2, 4'hF, 4'h0};
		foreach (ks[i]) begin
			host.wr1(1'h1, 2'h3, ks[i], 3'h1, 1'h1);
			@(negedge mclk);
			check(osc_bias, 2'h3, "bias");
			check(fb_halve, 1'h1, "halve");
			clk_len(hi, lo);
			check(hi, ks[i], "half period high");
			if (ks[i] != 4'h0) check(lo, ks[i], "half period low");
		end
		host.wr1(1'h0, 2'h3, 4'h4, 3'h7, 1'h1);
		@(negedge mclk);
		check(osc_enable, 1'h0, "osc off");
		tick_gap(hi);
		check(hi, 9'h007, "ref by seven");
		host.wr0(8'h17, 15'h0000, 3'h2);
		repeat (16) begin
			@(negedge mclk);
			check(status_mux_pin, pfd_ref_tick, "mux ref");
		end
		host.wr0(8'h17, 15'h0000, 3'h5);
		repeat (8) begin
			@(negedge mclk);
			check(status_mux_pin, 1'h0, "mux unused");
		end
		$display("test divided_ref_output done");
	endtask
	task automatic t_frac();
		int sum;
		host.wr1(1'h1, 2'h1, 4'h3, 3'h1, 1'h1);
		host.wr0(8'hFF, 15'h4000, 3'h3);
		repeat (3) @(negedge mclk);
		sum = 0;
		repeat (4) begin @(negedge mclk); sum += fb_div_n; end
		check(sum, 9'h1FE, "sum minus 512");
		repeat (8) begin @(negedge mclk); check(status_mux_pin, divided_ref_output, "mux clk"); end
		$display("test frac done");
	endtask
	task automatic t_lock();
		host.wr0(8'h40, 15'h0000, 3'h1);
		repeat (4) pfd(8'h0A);
		repeat (2) @(negedge mclk);
		check(lock_detect, 1'h0, "lock early");
		pfd(8'h0A);
		repeat (2) @(negedge mclk);
		check(lock_detect, 1'h1, "lock set");
		check(status_mux_pin, 1'h1, "mux lock");
		pfd(8'h18);
		repeat (2) @(negedge mclk);
		check(lock_detect, 1'h1, "lock held");
		pfd(8'h19);
		repeat (2) @(negedge mclk);
		check(lock_detect, 1'h0, "lock cleared");
		$display("test lock done");
	endtask
	task automatic t_ce_low();
		int hi, lo;
		@(posedge mclk);
		chip_enable <= 1'h0;
		repeat (5) @(negedge mclk);
		check(osc_enable, 1'h0, "osc off by ce");
		check(regulator_ready, 1'h0, "ready gone");
		@(posedge mclk);
		chip_enable <= 1'h1;
		host.wait_ready();
		@(negedge mclk);
		check(osc_bias, 2'h0, "bias cleared");
		check(status_mux_pin, 1'h1, "mux back to ready");
		check(fb_div_n, 9'h017, "int cleared");
		check(fb_halve, 1'h0, "halve cleared");
		clk_len(hi, lo);
		check(hi, 9'h004, "ratio cleared");
		$display("test chip enable done");
	endtask
	// ==========================================================
	// run control
	task automatic give_verdict();
		$display("checks %0d, mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	initial begin
		repeat (20) @(posedge mclk);
		rst <= 1'h0;
		t_defaults();
		t_divided_ref_output();
		t_frac();
		t_lock();
		t_ce_low();
		give_verdict();
	end
	// whole run is under a thousand cycles; this is far beyond it
	initial begin
		#500000;
		miscompares++;
		give_verdict();
	end
endmodule
